// >>> rtl/windowed_watchdog_clock_monitor.sv
// windowed watchdog, clock monitor and illegal-condition helpers
// assumes sys_clk_in is the instruction-cycle clock, fault pin wired to reset logic
`timescale 1ns/1ns
`default_nettype none

module windowed_watchdog_clock_monitor #(
   parameter int CM_TIMEOUT = wdog_pkg::CLK_MHZ * 1_000_000 / wdog_pkg::CM_OK_HZ
) (
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic [7:0] option_byte_in,
   input  wire logic       svc_wr_in,
   input  wire logic [7:0] svc_wdata_in,
   output logic      [7:0] svc_rdata_out,
   input  wire logic       halt_in,
   input  wire logic       idle_in,
   input  wire logic       crystal_osc_in,
   input  wire logic       oscillator_startup_delay_sel_in,
   input  wire logic       clock_input_pin_tick_in,
   input  wire logic       idle_pend_clr_in,
   output logic            idle_tick_pending_out,
   input  wire logic       fault_output_pin_in,
   output logic            fault_output_pin_out,
   output logic            fault_output_pin_oe_out,
   output logic            port_g_bit_one_wdog_out,
   input  wire logic [11:0] rom_addr_in,
   input  wire logic [11:0] rom_size_in,
   input  wire logic [7:0] rom_data_in,
   output logic      [7:0] rom_fetch_out,
   input  wire logic [6:0] ram_addr_in,
   input  wire logic [7:0] ram_data_in,
   output logic      [7:0] ram_rdata_out,
   output logic      [7:0] sp_reset_out
);

   // ******************************
   // state
   // ******************************
   // power-up value only: reset leaves the idle counter running
   wdog_pkg::wd_state_s s_q = '0;
   wdog_pkg::wd_state_s s_d;
   logic [31:0]         cm_gap_q;
   logic                wd_en;
   logic [16:0]         upper;
   logic                key_ok, all_ok, early, late, active;

   assign wd_en = (option_byte_in[wdog_pkg::OPT_WD_POS] == wdog_pkg::OPT_WD_ON);

   always_comb begin
      case (s_q.win)
         2'h0:    upper = wdog_pkg::UPPER_8K;
         2'h1:    upper = wdog_pkg::UPPER_16K;
         2'h2:    upper = wdog_pkg::UPPER_32K;
         default: upper = wdog_pkg::UPPER_64K;
      endcase
   end

   assign key_ok = svc_wdata_in[wdog_pkg::KEY_HI_POS:wdog_pkg::KEY_LO_POS] == wdog_pkg::KEY_VALUE;
   assign all_ok = key_ok && (svc_wdata_in[wdog_pkg::WIN_HI_POS:wdog_pkg::WIN_LO_POS] == s_q.win)
                   && (svc_wdata_in[wdog_pkg::CM_POS] == s_q.cm_en);
   assign active = wd_en && !halt_in && !idle_in;
   assign early  = s_q.configured && (s_q.count < wdog_pkg::LOWER_LIMIT);
   assign late   = (s_q.count >= upper);

   // monitor gap counter, runs in halt and idle
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || clock_input_pin_tick_in) begin
         cm_gap_q <= 32'h0000_0000;
      end else if (cm_gap_q < CM_TIMEOUT) begin
         cm_gap_q <= cm_gap_q + 32'h0000_0001;
      end
   end

   // ******************************
   // next state
   // ******************************
   always_comb begin
      s_d = s_q;
      s_d.halt_prev = halt_in;
      s_d.idle_prev = idle_in;
      s_d.pin_low   = !fault_output_pin_in;
      s_d.cm_err = wd_en && s_q.cm_en && (cm_gap_q >= CM_TIMEOUT);
      // idle tick, set wins over clear
      s_d.idle_cnt = s_q.idle_cnt + 14'h0001;
      if (idle_pend_clr_in) begin
         s_d.idle_pend = 1'b0;
      end
      if (s_d.idle_cnt[wdog_pkg::IDLE_TICK_BIT] != s_q.idle_cnt[wdog_pkg::IDLE_TICK_BIT]) begin
         s_d.idle_pend = 1'b1;
      end
      s_d.rd_data = {s_q.win, 5'h00, s_q.cm_en};
      case (s_q.state)
         wdog_pkg::ST_RUN: begin
            if (active && !late) begin
               s_d.count = s_q.count + 17'h0_0001;
            end
            if (s_q.halt_prev && !halt_in &&
                (crystal_osc_in || oscillator_startup_delay_sel_in)) begin
               s_d.count = 17'h0_0000;
            end
            if (s_q.idle_prev && !idle_in) begin
               s_d.count = 17'h0_0000;
            end
            if (active && svc_wr_in) begin
               if (!s_q.configured) begin
                  if (key_ok) begin
                     s_d.configured = 1'b1;
                     s_d.win   = svc_wdata_in[wdog_pkg::WIN_HI_POS:wdog_pkg::WIN_LO_POS];
                     s_d.cm_en = svc_wdata_in[wdog_pkg::CM_POS];
                     s_d.count = 17'h0_0000;
                  end else begin
                     s_d.state = wdog_pkg::ST_FAULT;
                  end
               end else if (all_ok && !early) begin
                  s_d.count = 17'h0_0000;
               end else begin
                  s_d.state = wdog_pkg::ST_FAULT;
               end
            end
            if (active && late) begin
               s_d.state = wdog_pkg::ST_FAULT;
            end
            s_d.hold = wdog_pkg::HOLD_CYC;
         end
         wdog_pkg::ST_FAULT: begin
            if (s_q.pin_low) begin
               s_d.hold = s_q.hold - 6'h01;
               if (s_q.hold == 6'h01) begin
                  s_d.state = wdog_pkg::ST_RELEASE;
               end
            end
         end
         wdog_pkg::ST_RELEASE: begin
            if (!s_q.pin_low) begin
               s_d.count = 17'h0_0000;
               s_d.state = wdog_pkg::ST_RUN;
            end
         end
         default: begin
            s_d.state = wdog_pkg::ST_RUN;
         end
      endcase
      if (s_q.cm_err) begin
         s_d.hold  = wdog_pkg::HOLD_CYC;
         s_d.state = wdog_pkg::ST_FAULT;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         s_q.state      <= wdog_pkg::ST_RUN;
         s_q.configured <= 1'b0;
         s_q.win        <= wdog_pkg::WIN_RESET;
         s_q.cm_en      <= wdog_pkg::CM_RESET;
         s_q.count      <= 17'h0_0000;
         s_q.hold       <= wdog_pkg::HOLD_CYC;
         s_q.cm_err     <= 1'b0;
         s_q.idle_pend  <= 1'b0;
         s_q.halt_prev  <= 1'b0;
         s_q.idle_prev  <= 1'b0;
         s_q.pin_low    <= 1'b0;
         s_q.rd_data    <= 8'h00;
         s_q.idle_cnt   <= s_d.idle_cnt;
      end else begin
         s_q <= s_d;
      end
   end

   // ******************************
   // outputs
   // ******************************
   assign svc_rdata_out           = s_q.rd_data;
   assign idle_tick_pending_out   = s_q.idle_pend;
   assign fault_output_pin_out    = 1'b0;
   assign fault_output_pin_oe_out = !srst_in && (s_q.state == wdog_pkg::ST_FAULT);
   assign port_g_bit_one_wdog_out = wd_en;
   assign rom_fetch_out = (rom_addr_in < rom_size_in) ? rom_data_in : wdog_pkg::TRAP_OPCODE;
   assign ram_rdata_out = (ram_addr_in >= wdog_pkg::RAM_HOLE_LO) ? wdog_pkg::RAM_HOLE_VAL
                                                                 : ram_data_in;
   assign sp_reset_out  = wdog_pkg::SP_RESET;

   // ******************************
   // sequences
   // ******************************
   sequence hold_begin_seq;
      s_q.state == wdog_pkg::ST_FAULT && s_q.pin_low && !s_q.cm_err
      && s_q.hold == wdog_pkg::HOLD_CYC;
   endsequence
   sequence hold_end_seq;
      s_q.state == wdog_pkg::ST_RELEASE || s_q.cm_err;
   endsequence

   // ******************************
   // checks
   // ******************************
   a_late_fault: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && active && late && !s_q.cm_err)
      |=> s_q.state == wdog_pkg::ST_FAULT)
      else $error("late service did not fault");
   a_key_readback: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      svc_rdata_out[5:1] == 5'h00)
      else $error("key field visible on read");
   a_cfg_once: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      s_q.configured |=> $stable(s_q.win) && $stable(s_q.cm_en))
      else $error("settings changed after configuration");
   a_bad_match: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && active && s_q.configured && svc_wr_in && !all_ok)
      |=> s_q.state == wdog_pkg::ST_FAULT)
      else $error("mismatching service accepted");
   a_early_svc: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && active && svc_wr_in && early)
      |=> s_q.state == wdog_pkg::ST_FAULT)
      else $error("early service accepted");
   a_first_svc: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && active && !s_q.configured && svc_wr_in && key_ok
       && !late && !s_q.cm_err) |=> s_q.state == wdog_pkg::ST_RUN && s_q.count == 17'h0_0000)
      else $error("initial service refused");
   a_hold_time: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      hold_begin_seq |-> ##[16:32] hold_end_seq)
      else $error("fault hold length wrong");
   a_suspend: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (halt_in && $past(halt_in) && s_q.state == wdog_pkg::ST_RUN
       && $past(s_q.state) == wdog_pkg::ST_RUN) |-> $stable(s_q.count))
      else $error("window counted in halt");
   a_halt_reload: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && s_q.halt_prev && !halt_in
       && (crystal_osc_in || oscillator_startup_delay_sel_in)) |=> s_q.count == 17'h0_0000)
      else $error("window not reloaded after halt");
   a_halt_resume: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && s_q.halt_prev && !halt_in && !crystal_osc_in
       && !oscillator_startup_delay_sel_in && active && !late && !svc_wr_in && !s_q.idle_prev)
      |=> s_q.count == $past(s_q.count) + 17'h0_0001)
      else $error("window lost its count after halt");
   a_idle_service: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_RUN && s_q.idle_prev && !idle_in)
      |=> s_q.count == 17'h0_0000)
      else $error("idle exit did not restart window");
   a_fault_ignore: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.state == wdog_pkg::ST_FAULT && svc_wr_in)
      |=> $stable(s_q.count) && $stable(s_q.configured))
      else $error("service taken during fault");
   a_cm_hold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      s_q.cm_err |=> fault_output_pin_oe_out)
      else $error("monitor error did not hold the pin");
   a_idle_pend: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (s_q.idle_cnt[11:0] == 12'hFFF) |=> s_q.idle_pend)
      else $error("idle tick did not set pending");
   a_wd_off: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (!wd_en && !s_q.cm_err && s_q.state == wdog_pkg::ST_RUN)
      |=> s_q.state == wdog_pkg::ST_RUN)
      else $error("disabled watchdog faulted");
   a_rom_trap: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (rom_addr_in >= rom_size_in) |-> rom_fetch_out == 8'h00)
      else $error("undefined fetch not zero");

endmodule : windowed_watchdog_clock_monitor

`default_nettype wire

// >>> rtl/wdog_pkg.sv
// package for the windowed watchdog and clock monitor
// assumes one instruction-cycle clock and a synchronous reset
package wdog_pkg;

   // ******************************
   // service register layout
   // ******************************
   localparam int          WIN_HI_POS   = 7;
   localparam int          WIN_LO_POS   = 6;
   localparam int          KEY_HI_POS   = 5;
   localparam int          KEY_LO_POS   = 1;
   localparam int          CM_POS       = 0;
   localparam logic [4:0]  KEY_VALUE    = 5'h0C;
   localparam logic [1:0]  WIN_RESET    = 2'h3;
   localparam logic        CM_RESET     = 1'b1;
   localparam logic        OPT_WD_ON    = 1'b0;
   localparam int          OPT_WD_POS   = 2;

   // ******************************
   // window limits in cycles
   // ******************************
   localparam logic [16:0] LOWER_LIMIT  = 17'h0_0100;
   localparam logic [16:0] UPPER_8K     = 17'h0_2000;
   localparam logic [16:0] UPPER_16K    = 17'h0_4000;
   localparam logic [16:0] UPPER_32K    = 17'h0_8000;
   localparam logic [16:0] UPPER_64K    = 17'h1_0000;

   // ******************************
   // timing
   // ******************************
   localparam int          CLK_MHZ      = 100;
   localparam int          HOLD_MIN_CYC = 16;
   localparam int          HOLD_MAX_CYC = 32;
   localparam logic [5:0]  HOLD_CYC     = 6'h14;
   localparam int          CM_MIN_HZ    = 10;
   localparam int          CM_OK_HZ     = 10_000;
   localparam int          IDLE_TICK_BIT = 12;

   // ******************************
   // rom and ram corner values
   // ******************************
   localparam logic [7:0]  TRAP_OPCODE  = 8'h00;
   localparam logic [7:0]  SP_RESET     = 8'h6F;
   localparam logic [6:0]  RAM_HOLE_LO  = 7'h70;
   localparam logic [7:0]  RAM_HOLE_VAL = 8'hFF;

   typedef enum logic [1:0] {ST_RUN, ST_FAULT, ST_RELEASE} fault_state_e;

   typedef struct packed {
      fault_state_e state;
      logic         configured;
      logic [1:0]   win;
      logic         cm_en;
      logic [16:0]  count;
      logic [5:0]   hold;
      logic         cm_err;
      logic [13:0]  idle_cnt;
      logic         idle_pend;
      logic         halt_prev;
      logic         idle_prev;
      logic         pin_low;
      logic [7:0]   rd_data;
   } wd_state_s;

endpackage : wdog_pkg

// >>> sim/fault_pad_model.sv
// pad of the fault pin: weak pull-up plus external reset logic
// assumes the device pulls the pad to its drive value while oe is high
`timescale 1ns/1ns
`default_nettype none
module fault_pad_model (
   input  wire logic oe_in,
   input  wire logic drv_in,
   output logic      pad_out,
   output logic      reset_req_out
);
   assign pad_out       = oe_in ? drv_in : 1'b1;
   assign reset_req_out = ~pad_out;
endmodule : fault_pad_model
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench of the windowed watchdog and clock monitor
// assumes a fault pad model on the fault pin, monitor timeout shortened to 50
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
   typedef struct packed {logic [2:0] sel; logic [7:0] exp;} note_s;
   logic        sys_clk_in = 0, srst_in = 1, wr = 0, tick_on = 1, tick = 0, clr = 0;
   logic        halt = 0, idle = 0, xtal = 0, dly = 0;
   logic [7:0]  opt = 8'h00, wd = 8'h00, rom_d = 8'h00, ram_d = 8'h00;
   logic [11:0] rom_a = 12'h000;
   logic [6:0]  ram_a = 7'h00;
   logic [7:0]  rdata, rom_f, ram_f, sp;
   logic        oe, drv, pad, pg, pend;
   logic [16:0] rnd = 17'h1_7908;
   int          failures = 0, checked = 0, n, i, tk = 0;
   note_s       notes[$], nt;
   // ************
   // clock, ticks, dut
   // ************
   initial forever #5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      tk <= (tk == 9) ? 0 : tk + 1;
      tick <= tick_on && tk == 0;
   end
   windowed_watchdog_clock_monitor #(.CM_TIMEOUT(50)) uut (.sys_clk_in(sys_clk_in),
      .srst_in(srst_in), .option_byte_in(opt), .svc_wr_in(wr), .svc_wdata_in(wd),
      .svc_rdata_out(rdata), .halt_in(halt), .idle_in(idle), .crystal_osc_in(xtal),
      .oscillator_startup_delay_sel_in(dly), .clock_input_pin_tick_in(tick),
      .idle_pend_clr_in(clr), .idle_tick_pending_out(pend), .fault_output_pin_in(pad),
      .fault_output_pin_out(drv), .fault_output_pin_oe_out(oe),
      .port_g_bit_one_wdog_out(pg), .rom_addr_in(rom_a), .rom_size_in(12'h800),
      .rom_data_in(rom_d), .rom_fetch_out(rom_f), .ram_addr_in(ram_a),
      .ram_data_in(ram_d), .ram_rdata_out(ram_f), .sp_reset_out(sp));
   fault_pad_model pad_m (.oe_in(oe), .drv_in(drv), .pad_out(pad), .reset_req_out());
   // ************
   // notes and checking
   // ************
   function automatic logic [16:0] lfsr(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction : lfsr
   function automatic logic [7:0] obs(input logic [2:0] s);
      case (s)
         3'h0: return rdata;
         3'h1: return {7'h00, oe};
         3'h2: return rom_f;
         3'h3: return ram_f;
         3'h4: return sp;
         3'h5: return {7'h00, pg};
         default: return {7'h00, pend};
      endcase
   endfunction : obs
   task automatic note(input logic [2:0] s, input logic [7:0] e);
      notes.push_back({s, e});
   endtask : note
   always @(negedge sys_clk_in) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         `CHK(obs(nt.sel), nt.exp)
      end
   end
   task automatic svc(input logic [7:0] d);
      @(posedge sys_clk_in);
      wr <= 1'b1;
      wd <= d;
      @(posedge sys_clk_in);
      wr <= 1'b0;
   endtask : svc
   task automatic fault_len(input int lo, input int hi);
      n = 0;
      @(negedge sys_clk_in);
      while (oe === 1'b1 && n < 200) begin
         @(negedge sys_clk_in);
         n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1)
      repeat (3) @(negedge sys_clk_in);
   endtask : fault_len
   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      repeat (30000) @(posedge sys_clk_in);
      failures++;
      close_out();
   end
   // ************
   // scenarios
   // ************
   initial begin
      repeat (10) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      @(posedge sys_clk_in);
      note(0, 8'hC1);
      note(1, 8'h00);
      note(4, 8'h6F);
      note(5, 8'h01);
      $display("test reset done");
      svc(8'h19);
      note(1, 8'h00);
      repeat (2) @(posedge sys_clk_in);
      note(0, 8'h01);
      svc(8'h19);
      note(1, 8'h01);
      fault_len(16, 34);
      repeat (300) @(posedge sys_clk_in);
      svc(8'h19);
      note(1, 8'h00);
      repeat (300) @(posedge sys_clk_in);
      svc(8'h18);
      note(1, 8'h01);
      fault_len(16, 34);
      $display("test service done");
      repeat (8150) @(posedge sys_clk_in);
      note(1, 8'h00);
      note(6, 8'h01);
      n = 0;
      while (oe !== 1'b1 && n < 100) begin
         @(negedge sys_clk_in);
         n++;
      end
      `CHK(n >= 30 && n <= 60, 1'b1)
      fault_len(16, 34);
      @(posedge sys_clk_in);
      clr <= 1'b1;
      @(posedge sys_clk_in);
      clr <= 1'b0;
      @(posedge sys_clk_in);
      note(6, 8'h00);
      $display("test late done");
      tick_on <= 1'b0;
      repeat (100) @(posedge sys_clk_in);
      note(1, 8'h01);
      svc(8'h19);
      repeat (98) @(posedge sys_clk_in);
      note(1, 8'h01);
      tick_on <= 1'b1;
      fault_len(16, 50);
      $display("test monitor done");
      repeat (300) @(posedge sys_clk_in);
      halt <= 1'b1;
      repeat (8000) @(posedge sys_clk_in);
      halt <= 1'b0;
      svc(8'h19);
      note(1, 8'h00);
      for (i = 0; i < 2; i++) begin
         repeat (300) @(posedge sys_clk_in);
         xtal <= i[0];
         dly  <= ~i[0];
         halt <= 1'b1;
         repeat (10) @(posedge sys_clk_in);
         halt <= 1'b0;
         svc(8'h19);
         note(1, 8'h01);
         fault_len(16, 34);
      end
      repeat (300) @(posedge sys_clk_in);
      idle <= 1'b1;
      repeat (10) @(posedge sys_clk_in);
      idle <= 1'b0;
      svc(8'h19);
      note(1, 8'h01);
      fault_len(16, 34);
      halt    <= 1'b1;
      tick_on <= 1'b0;
      repeat (100) @(posedge sys_clk_in);
      note(1, 8'h01);
      tick_on <= 1'b1;
      halt    <= 1'b0;
      fault_len(16, 50);
      $display("test low power done");
      for (i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         @(posedge sys_clk_in);
         rom_a <= rnd[11:0];
         rom_d <= rnd[7:0];
         ram_a <= rnd[16:10];
         ram_d <= rnd[15:8];
         note(2, rnd[11:0] >= 12'h800 ? 8'h00 : rnd[7:0]);
         note(3, rnd[16:10] >= 7'h70 ? 8'hFF : rnd[15:8]);
      end
      @(posedge sys_clk_in);
      opt <= 8'h04;
      @(posedge sys_clk_in);
      note(5, 8'h00);
      @(negedge sys_clk_in);
      $display("test misc done");
      @(posedge sys_clk_in);
      opt     <= 8'h00;
      srst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      @(posedge sys_clk_in);
      note(0, 8'hC1);
      svc(8'h99);
      repeat (2) @(posedge sys_clk_in);
      note(0, 8'h81);
      repeat (300) @(posedge sys_clk_in);
      svc(8'h19);
      note(1, 8'h01);
      fault_len(16, 34);
      $display("test second reset done");
      close_out();
   end
endmodule : tb
`default_nettype wire
